// File: tal_alarm_window.v
// Temperature readout, alarm window limits, alert logic and APB slave
`timescale 1ns/10ps
`include "tal_defines.vh"
module tal_alarm_window (
   input  wire        i_clock,
   input  wire        i_rst_n,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output wire        o_pready,
   output reg  [31:0] o_prdata,
   output wire        o_pslverr,
   input  wire        i_conv_done,
   input  wire [10:0] i_conv_temp,
   output reg         o_alert,
   output wire        o_irq
);
   reg  [15:0] cfg;
   reg  [12:0] temp;
   reg  [15:0] crit;
   reg  [15:0] hyst;
   reg  [3:0]  irq_stat;
   reg  [3:0]  irq_mask;
   reg         latched;
   reg         conv_q;
   reg         conv_done_d;
   reg  [2:0]  trip_d;
   wire [15:0] upper;
   wire [15:0] lower;
   wire [2:0]  trip;
   wire        locked;
   wire        access;
   wire        wr;
   wire        mapped;
   wire        cond;
   wire        clr_alert;
   wire [3:0]  events;
   reg  [31:0] next_rdata;
   reg  [10:0] conv_temp_q;
   reg  [10:0] conv_temp_s;
   wire [12:0] temp_word;
   wire        sel_cfg;
   wire        sel_temp;
   wire        sel_upper;
   wire        sel_lower;
   wire        sel_crit;
   wire        sel_hyst;
   wire        sel_stat;
   wire        sel_mask;
   wire        cfg_wr;
   wire        upper_wr;
   wire        lower_wr;
   wire        crit_wr;
   wire        hyst_wr;
   wire        stat_wr;
   wire        mask_wr;
   wire [2:0]  trip_rise;
   wire [3:0]  next_stat;
   wire [15:0] rd_cfg;
   wire [15:0] rd_temp;
   genvar      gi;

   // Register map, byte addresses on the APB side
   //   0x004 configuration: mode, alert enable, alert status, clear, locks
   //   0x008 readout: trip status 15:13, sign 12, reading 11:1, bit 0 zero
   //   0x00C upper limit: sign 12, value 11:2 in quarter degrees
   //   0x010 lower limit: same layout as the upper limit
   //   0x014 critical limit: same layout, frozen by the critical lock
   //   0x018 hysteresis: same layout, frozen by either lock
   //   0x01C interrupt status: write one to clear, a new event wins
   //   0x020 interrupt mask: same layout as the status
   // Interrupt bits: 0 below, 1 above, 2 critical, 3 new conversion
   // Locks only ever set; nothing but reset releases them

   // Configuration bits
   //   0 event mode: 0 comparator, 1 latched interrupt
   //   3 alert output enable
   //   4 alert status, read only, mirrors the pin
   //   5 clear alert, write only, reads zero
   //   6 window lock, 7 critical lock
   //   Mode and enable frozen while either lock is set

   // Full 12-bit address compare; aliases would hide software bugs
   assign sel_cfg   = (i_paddr == `TAL_CFG_ADDR);
   assign sel_temp  = (i_paddr == `TAL_TEMP_ADDR);
   assign sel_upper = (i_paddr == `TAL_UPPER_ADDR);
   assign sel_lower = (i_paddr == `TAL_LOWER_ADDR);
   assign sel_crit  = (i_paddr == `TAL_CRIT_ADDR);
   assign sel_hyst  = (i_paddr == `TAL_HYST_ADDR);
   assign sel_stat  = (i_paddr == `TAL_IRQ_STAT_ADDR);
   assign sel_mask  = (i_paddr == `TAL_IRQ_MASK_ADDR);

   // Single-cycle APB access phase, zero wait states
   assign access    = i_psel & i_penable;
   assign wr        = access & i_pwrite;
   assign o_pready  = 1'b1;
   assign mapped    = sel_cfg | sel_temp | sel_upper | sel_lower |
                      sel_crit | sel_hyst | sel_stat | sel_mask;
   assign o_pslverr = access & ~mapped;
   assign locked    = cfg[`TAL_CFG_CRIT_LOCK] | cfg[`TAL_CFG_WINDOW_LOCK];

   // Write strobes, one per writable register, qualified by the access phase
   assign cfg_wr    = wr & sel_cfg;
   assign upper_wr  = wr & sel_upper;
   assign lower_wr  = wr & sel_lower;
   assign crit_wr   = wr & sel_crit;
   assign hyst_wr   = wr & sel_hyst;
   assign stat_wr   = wr & sel_stat;
   assign mask_wr   = wr & sel_mask;
   assign clr_alert = cfg_wr & i_pwdata[`TAL_CFG_CLEAR_ALERT];

   // Configuration: locks are set-only, control bits frozen while locked
   // A lock and a mode change in one word: the mode sees the old locks
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg <= 16'h0000;
      end else if (cfg_wr) begin
         if (i_pwdata[`TAL_CFG_CRIT_LOCK]) cfg[`TAL_CFG_CRIT_LOCK] <= 1'b1;
         if (i_pwdata[`TAL_CFG_WINDOW_LOCK]) cfg[`TAL_CFG_WINDOW_LOCK] <= 1'b1;
         if (!locked) begin
            cfg[`TAL_CFG_EVENT_MODE]   <= i_pwdata[`TAL_CFG_EVENT_MODE];
            cfg[`TAL_CFG_EVENT_OUT_EN] <= i_pwdata[`TAL_CFG_EVENT_OUT_EN];
         end
      end
   end

   // Critical and hysteresis held here; critical lock guards the critical limit
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         crit <= `TAL_LIMIT_RESET;
         hyst <= `TAL_HYST_RESET;
      end else begin
         if (crit_wr && !cfg[`TAL_CFG_CRIT_LOCK])
            crit <= i_pwdata[15:0] & `TAL_LIMIT_MASK;
         if (hyst_wr && !locked)
            hyst <= i_pwdata[15:0] & `TAL_LIMIT_MASK;
      end
   end

   tal_limit_reg u_upper (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_write (upper_wr),
      .i_lock  (cfg[`TAL_CFG_WINDOW_LOCK]),
      .i_wdata (i_pwdata[15:0]),
      .o_value (upper)
   );

   tal_limit_reg u_lower (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_write (lower_wr),
      .i_lock  (cfg[`TAL_CFG_WINDOW_LOCK]),
      .i_wdata (i_pwdata[15:0]),
      .o_value (lower)
   );

   // Converter strobe arrives from the analog domain, so it is synchronised
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_q      <= 1'b0;
         conv_done_d <= 1'b0;
      end else begin
         conv_q      <= i_conv_done;
         conv_done_d <= conv_q;
      end
   end

   // Reading crosses too; two stages, and the strobe lags by the same two
   // edges, so the word has settled whenever the strobe says so
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_temp_q <= 11'h000;
         conv_temp_s <= 11'h000;
      end else begin
         conv_temp_q <= i_conv_temp;
         conv_temp_s <= conv_temp_q;
      end
   end

   // Sign copied into bit 12, reading in 11:1, bit 0 held at zero
   assign temp_word = {conv_temp_s[10], conv_temp_s, 1'b0};

   // Reading latched on the synchronised strobe; data assumed stable by then
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         temp <= 13'h0000;
      end else if (conv_done_d) begin
         temp <= temp_word;
      end
   end

   // Limits compared directly from the live registers against the new reading
   // Same word as the readout latch, so status and reading never disagree
   tal_trip_eval u_eval (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_sample(conv_done_d),
      .i_temp  (temp_word),
      .i_upper (upper[12:0]),
      .i_lower (lower[12:0]),
      .i_crit  (crit[12:0]),
      .i_hyst  (hyst[12:0]),
      .o_trip  (trip)
   );

   // Any trip condition and the rising trip bits against the last sample
   assign cond      = |trip;
   assign trip_rise = trip & ~trip_d;

   // Interrupt mode latches the alert until cleared
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latched <= 1'b0;
         trip_d  <= 3'h0;
      end else begin
         trip_d <= trip;
         if (trip_rise != 3'h0)
            latched <= 1'b1;                           // Set beats clear
         else if (clr_alert && cfg[`TAL_CFG_EVENT_MODE])
            latched <= 1'b0;
      end
   end

   // Alert pin register; comparator mode follows trip, costs one cycle
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alert <= 1'b0;
      end else begin
         o_alert <= cfg[`TAL_CFG_EVENT_OUT_EN] &
                    (cfg[`TAL_CFG_EVENT_MODE] ? latched : cond);
      end
   end

   // Sticky events: three trip rises plus a new conversion
   assign events = {conv_done_d, trip_rise};

   // Per-bit status: a written one clears, unless the same bit fires now
   generate
      for (gi = 0; gi < `TAL_IRQ_BITS; gi = gi + 1) begin : g_stat
         assign next_stat[gi] = events[gi] | (irq_stat[gi] & ~(stat_wr & i_pwdata[gi]));
      end
   endgenerate

   // Status and mask registers
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
      end else begin
         irq_stat <= next_stat;
         if (mask_wr)
            irq_mask <= i_pwdata[3:0];
      end
   end
   assign o_irq = |(irq_stat & irq_mask);

   // Configuration readback; bit 4 mirrors the pin, bit 5 is never stored
   assign rd_cfg  = {cfg[15:5], o_alert, cfg[3:0]};

   // Readout status comes from trip, not the alert pin
   assign rd_temp = {trip, temp} & 16'hFFFE;

   // Read mux; unmapped addresses read zero
   always @* begin
      next_rdata = 32'h00000000;
      case (i_paddr)
         `TAL_CFG_ADDR:      next_rdata[15:0] = rd_cfg;
         `TAL_TEMP_ADDR:     next_rdata[15:0] = rd_temp;
         `TAL_UPPER_ADDR:    next_rdata[15:0] = upper;
         `TAL_LOWER_ADDR:    next_rdata[15:0] = lower;
         `TAL_CRIT_ADDR:     next_rdata[15:0] = crit;
         `TAL_HYST_ADDR:     next_rdata[15:0] = hyst;
         `TAL_IRQ_STAT_ADDR: next_rdata[3:0]  = irq_stat;
         `TAL_IRQ_MASK_ADDR: next_rdata[3:0]  = irq_mask;
         default:            next_rdata = 32'h00000000;
      endcase
   end

   // Read data registered in the setup cycle so it is valid in access
   // Costs a flop bank but keeps the decode off the bus output path
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata <= 32'h00000000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= next_rdata;
      end
   end
endmodule // tal_alarm_window

// File: tal_defines.vh
// Register map, field positions and reset values for the alarm window block
`ifndef TAL_DEFINES_VH
`define TAL_DEFINES_VH
`define TAL_CFG_INDEX        8'h01
`define TAL_CFG_ADDR         12'h004
`define TAL_TEMP_ADDR        12'h008
`define TAL_UPPER_ADDR       12'h00C
`define TAL_LOWER_ADDR       12'h010
`define TAL_CRIT_ADDR        12'h014
`define TAL_HYST_ADDR        12'h018
`define TAL_IRQ_STAT_ADDR    12'h01C
`define TAL_IRQ_MASK_ADDR    12'h020
`define TAL_CFG_EVENT_MODE   0
`define TAL_CFG_EVENT_OUT_EN 3
`define TAL_CFG_EVENT_STATUS 4
`define TAL_CFG_CLEAR_ALERT  5
`define TAL_CFG_WINDOW_LOCK  6
`define TAL_CFG_CRIT_LOCK    7
`define TAL_TEMP_CRIT_BIT    15
`define TAL_TEMP_ABOVE_BIT   14
`define TAL_TEMP_BELOW_BIT   13
`define TAL_LIMIT_MASK       16'h1FFC
`define TAL_TEMP_MASK        16'h1FFE
`define TAL_LIMIT_RESET      16'h0000
`define TAL_HYST_RESET       16'h0000
`define TAL_IRQ_BITS         4
`endif

// File: tal_trip_eval.v
// Trip status evaluation with hysteresis for one temperature sample
`timescale 1ns/10ps
`include "tal_defines.vh"
module tal_trip_eval (
   input  wire        i_clock,
   input  wire        i_rst_n,
   input  wire        i_sample,
   input  wire [12:0] i_temp,
   input  wire [12:0] i_upper,
   input  wire [12:0] i_lower,
   input  wire [12:0] i_crit,
   input  wire [12:0] i_hyst,
   output reg  [2:0]  o_trip
);
   // Sign-extended temperature and limits, zero-extended hysteresis; 14 bits avoid overflow on subtract while hysteresis bit 12 is clear
   wire signed [13:0] t  = {i_temp[12], i_temp};
   wire signed [13:0] up = {i_upper[12], i_upper};
   wire signed [13:0] lo = {i_lower[12], i_lower};
   wire signed [13:0] cr = {i_crit[12], i_crit};
   wire signed [13:0] hy = {1'b0, i_hyst};
   reg  [2:0] next_trip;

   // Hysteresis: each bit keeps its state inside the dead band
   always @* begin
      next_trip = o_trip;
      if (t >= cr) next_trip[2] = 1'b1;
      else if (t < cr - hy) next_trip[2] = 1'b0;
      if (t > up) next_trip[1] = 1'b1;
      else if (t < up - hy) next_trip[1] = 1'b0;
      if (t < lo - hy) next_trip[0] = 1'b1;
      else if (t >= lo) next_trip[0] = 1'b0;
   end

   // Only a new conversion moves the status
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_trip <= 3'h0;
      end else if (i_sample) begin
         o_trip <= next_trip;
      end
   end
endmodule // tal_trip_eval

// File: tal_limit_reg.v
// One boundary register with lock and reserved-bit masking
`timescale 1ns/10ps
`include "tal_defines.vh"
module tal_limit_reg (
   input  wire        i_clock,
   input  wire        i_rst_n,
   input  wire        i_write,
   input  wire        i_lock,
   input  wire [15:0] i_wdata,
   output reg  [15:0] o_value
);
   // Locked writes dropped; reserved bits never stored
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_value <= `TAL_LIMIT_RESET;
      end else if (i_write && !i_lock) begin
         o_value <= i_wdata & `TAL_LIMIT_MASK;
      end
   end
endmodule // tal_limit_reg

// File: tal_alarm_window_asserts.sv
// Port checker for the alarm window block
`timescale 1ns/10ps
module tal_aw_chk (
   input wire        i_clock,
   input wire        i_rst_n,
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata,
   input wire        o_pslverr,
   input wire        i_conv_done,
   input wire        o_alert,
   input wire        o_irq
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // Access phase qualifiers and decode
   wire rd   = i_psel && i_penable && !i_pwrite;
   wire wr   = i_psel && i_penable && i_pwrite;
   wire mapd = i_paddr[1:0] == 2'h0 && i_paddr >= 12'h004 && i_paddr <= 12'h020;
   reg  [1:0]  lk;
   reg         md;
   reg  [15:0] up;
   // Shadow of locks, mode and upper limit; crit lock also freezes mode
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lk <= 2'h0;
         md <= 1'b0;
         up <= 16'h0000;
      end else begin
         if (wr && i_paddr == 12'h004) lk <= lk | i_pwdata[7:6];
         if (wr && i_paddr == 12'h004 && lk == 2'h0) md <= i_pwdata[0];
         if (wr && i_paddr == 12'h00C && !lk[0]) up <= i_pwdata[15:0] & 16'h1FFC;
      end
   end
   temp_lsb_a: assert property (rd && i_paddr == 12'h008 |-> o_prdata[0] == 1'b0
      && o_prdata[31:16] == 16'h0000) else $error("readout lsb or top not zero");
   limit_resv_a: assert property (rd && (i_paddr == 12'h00C || i_paddr == 12'h010)
      |-> (o_prdata & ~32'h1FFC) == 32'h0) else $error("limit reserved bits set");
   upper_value_a: assert property (rd && i_paddr == 12'h00C
      |-> o_prdata[15:0] == up) else $error("upper limit value wrong");
   mode_bit_a: assert property (rd && i_paddr == 12'h004
      |-> o_prdata[0] == md) else $error("event mode bit wrong");
   lock_bits_a: assert property (rd && i_paddr == 12'h004
      |-> o_prdata[7:6] == lk) else $error("lock bits wrong");
   clear_zero_a: assert property (rd && i_paddr == 12'h004 |-> !o_prdata[5])
      else $error("clear bit reads one");
   reset_quiet_a: assert property ($rose(i_rst_n) |-> !o_alert && !o_irq)
      else $error("alert or irq high after reset");
   irq_cause_a: assert property ($rose(o_irq) |-> $past(i_conv_done, 3) || $past(wr))
      else $error("irq rose without cause");
   irq_clear_a: assert property ($fell(o_irq) |-> $past(wr))
      else $error("irq fell without write");
   unmapped_err_a: assert property (i_psel && i_penable && !mapd |-> o_pslverr)
      else $error("unmapped access without error");
   cover property (rd && i_paddr == 12'h008);
   cover property ($rose(o_irq));
   cover property ($rose(o_alert));
endmodule // tal_aw_chk

bind tal_alarm_window tal_aw_chk u_chk (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pslverr(o_pslverr), .i_conv_done(i_conv_done), .o_alert(o_alert), .o_irq(o_irq)
);

// File: tal_conv_model.sv
// Converter stand-in delivering one temperature sample per request
`timescale 1ns/10ps
module tal_conv_model (
   input  wire        i_clock,
   input  wire        i_go,
   input  wire [10:0] i_temp,
   output reg         o_done,
   output reg  [10:0] o_temp
);
   reg [3:0] age = 4'hF;
   initial o_done = 1'b0;
   initial o_temp = 11'h000;
   // Done for four cycles, sample held seven, then scrambled so stale reads show
   always @(posedge i_clock) begin
      if (i_go) begin
         age <= 4'h0;
         o_temp <= i_temp;
      end else if (age != 4'hF) begin
         age <= age + 4'h1;
      end
      o_done <= i_go || age < 4'h3;
      if (!i_go && age >= 4'h6) o_temp <= ~o_temp;
   end
endmodule // tal_conv_model

// File: test_temp_alarm_window_logic.sv
// Self-checking bench for the alarm window block
`timescale 1ns/10ps
module test_temp_alarm_window_logic;
   reg          clk = 1'b0;
   reg          rst_n = 1'b0;
   reg          psel = 1'b0;
   reg          penable = 1'b0;
   reg          pwrite = 1'b0;
   reg   [11:0] paddr = 12'h000;
   reg   [31:0] pwdata = 32'h0;
   reg          go = 1'b0;
   reg   [10:0] temp = 11'h000;
   wire         pready;
   wire  [31:0] prdata;
   wire         pslverr;
   wire         done;
   wire  [10:0] ctemp;
   wire         alert;
   wire         irq;
   logic [31:0] r;
   logic        e;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cyc = 0;
   // 250 MHz clock
   always #2 clk = ~clk;
   tal_alarm_window u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_conv_done(done),
      .i_conv_temp(ctemp), .o_alert(alert), .o_irq(irq));
   tal_conv_model u_conv (.i_clock(clk), .i_go(go), .i_temp(temp), .o_done(done),
      .o_temp(ctemp));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wrt(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   // Alert output checked once the registered path has settled
   task automatic alc(input logic x);
      repeat (3) @(posedge clk);
      chk({31'h0, alert}, {31'h0, x});
   endtask
   task automatic conv(input logic [10:0] t);
      go <= 1'b1;
      temp <= t;
      @(posedge clk);
      go <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         finish_test;
      end
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(12'h004, 32'h0);
      rdc(12'h00C, 32'h0);
      wrt(12'h00C, 32'hFFFFFFFF);
      rdc(12'h00C, 32'h1FFC);
      wrt(12'h010, 32'hFFFFFFFF);
      rdc(12'h010, 32'h1FFC);
      wrt(12'h00C, 32'h190);
      wrt(12'h010, 32'h0);
      wrt(12'h014, 32'h7C0);
      wrt(12'h020, 32'h8);
      wrt(12'h004, 32'h9);
      rdc(12'h004, 32'h9);
      conv(11'h0CE);
      rdc(12'h008, 32'h419C);
      alc(1'b1);
      chk({31'h0, irq}, 32'h1);
      wrt(12'h01C, 32'hF);
      chk({31'h0, irq}, 32'h0);
      wrt(12'h020, 32'h0);
      conv(11'h732);
      rdc(12'h008, 32'h3E64);
      chk({31'h0, irq}, 32'h0);
      alc(1'b1);
      wrt(12'h020, 32'h8);
      chk({31'h0, irq}, 32'h1);
      wrt(12'h004, 32'h29);
      alc(1'b0);
      rdc(12'h004, 32'h9);
      wrt(12'h004, 32'h8);
      alc(1'b1);
      wrt(12'h004, 32'h0);
      wrt(12'h010, 32'h1E00);
      conv(11'h732);
      rdc(12'h008, 32'h1E64);
      conv(11'h3E0);
      rdc(12'h008, 32'hC7C0);
      wrt(12'h018, 32'h10);
      conv(11'h3D8);
      rdc(12'h008, 32'hC7B0);
      xfer(1'b0, 12'h040, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      wrt(12'h004, 32'h40);
      wrt(12'h004, 32'h1);
      rdc(12'h004, 32'h40);
      wrt(12'h00C, 32'h0);
      rdc(12'h00C, 32'h190);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(12'h004, 32'h0);
      rdc(12'h00C, 32'h0);
      finish_test;
   end
endmodule // test_temp_alarm_window_logic
